// *** rtl/drt_pkg.sv ***
// Shared constants and carrier types for the read-path device block.
// Assumes a single clk domain; the memory clock arrives as a sampled input.
package drt_pkg;

	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_SEED = 4'h4;
	localparam logic [3:0] OFS_STAT = 4'h8;
	localparam logic [3:0] OFS_RDCNT = 4'hC;

	localparam int CL_LSB = 0;
	localparam int AL_LSB = 4;
	localparam int BL8_BIT = 8;
	localparam int BUSY_BIT = 4;
	localparam logic [2:0] CL_RST = 3'h3;
	localparam logic [2:0] AL_RST = 3'h0;
	localparam logic BL8_RST = 1'b0;
	localparam logic [7:0] SEED_RST = 8'h00;

	localparam int BANKS = 4;
	localparam int SLOTS = 16;
	localparam int RL_W = 4;
	localparam int CNT_W = 5;
	localparam int AP_BIT = 10;
	localparam logic [RL_W-1:0] RL_MIN = 4'h1;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [CNT_W-1:0] HALF_BL4 = 5'h02;
	localparam logic [CNT_W-1:0] HALF_BL8 = 5'h04;
	localparam logic [2:0] BEAT_LAST4 = 3'h3;
	localparam logic [2:0] BEAT_LAST8 = 3'h7;

	// Command code is {cs_n, ras_n, cas_n, we_n}.
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_PRE = 4'h2;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] ba;
		logic [13:0] addr;
	} drt_cmd_t;

	typedef struct packed {
		logic valid;
		logic ap;
		logic [1:0] bank;
		logic [9:0] col;
	} drt_slot_t;

	typedef struct packed {
		logic [7:0] dq;
		logic dq_oe;
		logic dqs;
		logic dqs_n;
		logic dqs_oe;
	} drt_dout_t;

	typedef enum logic [1:0] {
		BST_IDLE = 2'b00,
		BST_PRE = 2'b01,
		BST_DATA = 2'b10
	} drt_bst_t;

endpackage : drt_pkg

// *** rtl/drt_bank.sv ***
// One bank's open-row flag with its auto precharge countdown.
// Assumes ck_rise is a one-cycle pulse per memory clock rising edge.
`timescale 1ns/1ps
`default_nettype none
module drt_bank (
	input wire logic clk, // System clock.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic ck_rise, // Memory clock rising edge seen.
	input wire logic act, // Activate to this bank.
	input wire logic pre, // Precharge hitting this bank.
	input wire logic rd_ap, // Read with auto precharge to this bank.
	input wire logic [drt_pkg::CNT_W-1:0] close_cnt, // Edges until close.
	output logic open // Row is open.
);
	logic [drt_pkg::CNT_W-1:0] cnt;
	wire closing = ck_rise && cnt == drt_pkg::CNT_ONE;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			open <= 1'b0;
			cnt <= '0;
		end
		else if (act)
		begin
			open <= 1'b1;
			cnt <= '0;
		end
		else if (pre)
		begin
			open <= 1'b0;
			cnt <= '0;
		end
		else if (rd_ap)
			cnt <= close_cnt;
		else if (ck_rise && cnt != '0)
		begin
			cnt <= cnt - drt_pkg::CNT_ONE;
			if (closing)
				open <= 1'b0;
		end
	end

	property p_ap_close;
		@(posedge clk) disable iff (!rstn)
		closing && !act && !pre && !rd_ap |=> !open;
	endproperty
	a_ap_close: assert property (p_ap_close)
		else $error("bank stayed open after auto precharge count");

	property p_ap_load;
		@(posedge clk) disable iff (!rstn)
		rd_ap && !act && !pre |=> cnt == $past(close_cnt) && open == $past(open);
	endproperty
	a_ap_load: assert property (p_ap_load)
		else $error("auto precharge countdown not armed by read");

	property p_no_ap;
		@(posedge clk) disable iff (!rstn)
		ck_rise && open && cnt == '0 && !act && !pre && !rd_ap |=> open;
	endproperty
	a_no_ap: assert property (p_no_ap)
		else $error("row closed without precharge or auto precharge");

	c_ap_close: cover property (@(posedge clk) disable iff (!rstn)
		closing ##1 !open);
endmodule : drt_bank
`default_nettype wire

// *** rtl/drt_top.sv ***
// Read path of a four-bank DDR2 device: command decode, latency pipe,
// DQ/DQS burst drive and bank open state, with a Wishbone register slave.
// Assumes the memory clock ck is far slower than clk and commands are
// stable around each ck rising edge.
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module drt_top (
	input wire logic clk, // System clock, 125 MHz.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic ck, // Memory clock from the controller.
	input wire drt_pkg::drt_cmd_t cmd, // Command, bank and address pins.
	input wire logic wb_cyc_i, // Wishbone cycle.
	input wire logic wb_stb_i, // Wishbone strobe.
	input wire logic wb_we_i, // Wishbone write enable.
	input wire logic [3:0] wb_adr_i, // Wishbone byte address.
	input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
	input wire logic [31:0] wb_dat_i, // Wishbone write data.
	output logic [31:0] wb_dat_o, // Wishbone read data.
	output logic wb_ack_o, // Wishbone acknowledge.
	output var drt_pkg::drt_dout_t dout // DQ and DQS drive with enables.
);
	logic [2:0] ck_s;
	logic ck_lvl;
	drt_pkg::drt_cmd_t cmd_s0, cmd_s1, cmd_s2;

	// Three stages; an edge counts once the last two agree.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ck_s <= '0;
			ck_lvl <= 1'b0;
			cmd_s0 <= '1;
			cmd_s1 <= '1;
			cmd_s2 <= '1;
		end
		else
		begin
			ck_s <= {ck_s[1:0], ck};
			ck_lvl <= (ck_s[1] == ck_s[2]) ? ck_s[2] : ck_lvl;
			cmd_s0 <= cmd;
			cmd_s1 <= cmd_s0;
			cmd_s2 <= cmd_s1;
		end
	end

	wire ck_agree = ck_s[1] == ck_s[2];
	wire ck_rise = ck_agree && ck_s[2] && !ck_lvl;
	wire ck_fall = ck_agree && !ck_s[2] && ck_lvl;
	wire take = ck_rise && cmd_s1 == cmd_s2;
	wire [3:0] code = {cmd_s2.cs_n, cmd_s2.ras_n, cmd_s2.cas_n, cmd_s2.we_n};
	wire is_act = take && code == drt_pkg::CMD_ACT;
	wire is_rd = take && code == drt_pkg::CMD_RD;
	wire is_pre = take && code == drt_pkg::CMD_PRE;
	wire a10 = cmd_s2.addr[drt_pkg::AP_BIT];

	logic [2:0] cl, al;
	logic bl8;
	logic [7:0] seed;
	logic [15:0] rd_cnt;
	logic [drt_pkg::BANKS-1:0] bank_open;

	wire [drt_pkg::RL_W-1:0] rl_raw = {1'b0, al} + {1'b0, cl};
	wire [drt_pkg::RL_W-1:0] rl = (rl_raw == '0) ? drt_pkg::RL_MIN : rl_raw;
	wire [drt_pkg::RL_W-1:0] rl_idx = rl - drt_pkg::RL_MIN;
	wire [2:0] beat_last = bl8 ? drt_pkg::BEAT_LAST8 : drt_pkg::BEAT_LAST4;
	wire [drt_pkg::CNT_W-1:0] close_cnt = {2'b00, al} +
		(bl8 ? drt_pkg::HALF_BL8 : drt_pkg::HALF_BL4);

	genvar b;
	generate
		for (b = 0; b < drt_pkg::BANKS; b++)
		begin : g_bank
			wire hit = cmd_s2.ba == 2'(b);
			drt_bank u_bank (
				.clk(clk),
				.rstn(rstn),
				.ck_rise(ck_rise),
				.act(is_act && hit),
				.pre(is_pre && (a10 || hit)),
				.rd_ap(is_rd && a10 && hit),
				.close_cnt(close_cnt),
				.open(bank_open[b])
			);
		end
	endgenerate

	// Latency pipe in ck rising edges; a READ enters at slot RL-1.
	drt_pkg::drt_slot_t slot [drt_pkg::SLOTS];
	drt_pkg::drt_slot_t next_slot [drt_pkg::SLOTS];
	drt_pkg::drt_slot_t new_slot;
	assign new_slot = '{valid: 1'b1, ap: a10, bank: cmd_s2.ba,
		col: cmd_s2.addr[9:0]};

	genvar i;
	generate
		for (i = 0; i < drt_pkg::SLOTS; i++)
		begin : g_slot
			if (i == drt_pkg::SLOTS - 1)
			begin : g_tail
				assign next_slot[i] = (is_rd && rl_idx == 4'(i)) ? new_slot : '0;
			end
			else
			begin : g_mid
				assign next_slot[i] = (is_rd && rl_idx == 4'(i)) ? new_slot :
					slot[i+1];
			end
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
					slot[i] <= '0;
				else if (ck_rise)
					slot[i] <= next_slot[i];
			end
		end
	endgenerate

	drt_pkg::drt_bst_t bst, next_bst;
	logic [2:0] beat, next_beat;
	logic [9:0] bcol, next_bcol;
	wire start = ck_rise && slot[0].valid;
	wire need_pre = next_slot[0].valid;
	wire last = beat == beat_last;

	always_comb
	begin
		next_bst = bst;
		next_beat = beat;
		next_bcol = bcol;
		unique case (bst)
			drt_pkg::BST_IDLE:
				if (ck_rise && need_pre)
					next_bst = drt_pkg::BST_PRE;
			drt_pkg::BST_PRE:
				if (start)
				begin
					next_bst = drt_pkg::BST_DATA;
					next_beat = '0;
					next_bcol = slot[0].col;
				end
			drt_pkg::BST_DATA:
				if (start)
				begin
					// A new burst at the boundary runs on seamlessly.
					next_beat = '0;
					next_bcol = slot[0].col;
				end
				else if (ck_rise && last)
					next_bst = need_pre ? drt_pkg::BST_PRE :
						drt_pkg::BST_IDLE;
				else if (ck_rise || ck_fall)
					next_beat = beat + 3'h1;
			default:
				next_bst = drt_pkg::BST_IDLE;
		endcase
	end

	wire next_data = next_bst == drt_pkg::BST_DATA;
	wire next_drive = next_bst != drt_pkg::BST_IDLE;
	wire next_dqs = next_data && !next_beat[0];
	drt_pkg::drt_dout_t next_dout;
	assign next_dout = '{dq: seed + next_bcol[7:0] + {5'h00, next_beat},
		dq_oe: next_data, dqs: next_dqs, dqs_n: !next_dqs,
		dqs_oe: next_drive};

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bst <= drt_pkg::BST_IDLE;
			beat <= '0;
			bcol <= '0;
			dout <= '{dq: 8'h00, dq_oe: 1'b0, dqs: 1'b0, dqs_n: 1'b1,
				dqs_oe: 1'b0};
		end
		else
		begin
			bst <= next_bst;
			beat <= next_beat;
			bcol <= next_bcol;
			dout <= next_dout;
		end
	end

	// Register slave: one-cycle answer, unmapped reads return zero.
	// Changing burst length mid-burst corrupts that burst; latency is fixed when the READ enters.
	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wb_wr = wb_req && wb_we_i;
	wire sel_ctrl = wb_adr_i == drt_pkg::OFS_CTRL;
	wire sel_seed = wb_adr_i == drt_pkg::OFS_SEED;
	wire [31:0] stat_word = {27'h0000000, bst != drt_pkg::BST_IDLE,
		bank_open};
	wire [31:0] ctrl_word = {23'h000000, bl8, 1'b0, al, 1'b0, cl};
	wire [31:0] rd_word = sel_ctrl ? ctrl_word :
		sel_seed ? {24'h000000, seed} :
		wb_adr_i == drt_pkg::OFS_STAT ? stat_word :
		wb_adr_i == drt_pkg::OFS_RDCNT ? {16'h0000, rd_cnt} : 32'h00000000;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
			cl <= drt_pkg::CL_RST;
			al <= drt_pkg::AL_RST;
			bl8 <= drt_pkg::BL8_RST;
			seed <= drt_pkg::SEED_RST;
			rd_cnt <= '0;
		end
		else
		begin
			wb_ack_o <= wb_req;
			wb_dat_o <= (wb_req && !wb_we_i) ? rd_word : 32'h00000000;
			if (wb_wr && sel_ctrl && wb_sel_i[0])
			begin
				cl <= wb_dat_i[drt_pkg::CL_LSB +: 3];
				al <= wb_dat_i[drt_pkg::AL_LSB +: 3];
			end
			if (wb_wr && sel_ctrl && wb_sel_i[1])
				bl8 <= wb_dat_i[drt_pkg::BL8_BIT];
			if (wb_wr && sel_seed && wb_sel_i[0])
				seed <= wb_dat_i[7:0];
			if (is_rd)
				rd_cnt <= rd_cnt + 16'h0001;
		end
	end

	// Helper history of READ edges, used only by the checks below.
	logic [drt_pkg::SLOTS-1:0] rd_hist;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rd_hist <= '0;
		else if (ck_rise)
			rd_hist <= {rd_hist[drt_pkg::SLOTS-2:0], is_rd};
	end

	property p_rl;
		@(posedge clk) disable iff (!rstn)
		start |-> rd_hist[rl_idx] ##1 (dout.dq_oe && dout.dqs && beat == 3'h0);
	endproperty
	a_rl: assert property (p_rl)
		else $error("first read element not at read latency");

	property p_ddr;
		@(posedge clk) disable iff (!rstn)
		bst == drt_pkg::BST_DATA && (ck_rise || ck_fall) && !start && !last
		|=> beat == $past(beat) + 3'h1 && dout.dqs == !beat[0] && dout.dq_oe;
	endproperty
	a_ddr: assert property (p_ddr)
		else $error("read element did not advance on clock edge");

	property p_pre;
		@(posedge clk) disable iff (!rstn)
		$rose(dout.dqs_oe) |-> !dout.dqs && dout.dqs_n && !dout.dq_oe;
	endproperty
	a_pre: assert property (p_pre)
		else $error("strobe preamble not low");

	property p_post;
		@(posedge clk) disable iff (!rstn)
		bst == drt_pkg::BST_DATA && last |-> !dout.dqs && dout.dqs_n;
	endproperty
	a_post: assert property (p_post)
		else $error("strobe not low with last element");

	property p_hiz;
		@(posedge clk) disable iff (!rstn)
		ck_rise && bst == drt_pkg::BST_DATA && last && !slot[0].valid
		|=> !dout.dq_oe;
	endproperty
	a_hiz: assert property (p_hiz)
		else $error("data outputs not released after burst");

	property p_seam;
		@(posedge clk) disable iff (!rstn)
		ck_rise && bst == drt_pkg::BST_DATA && last && slot[0].valid
		|=> dout.dq_oe && dout.dqs_oe && beat == 3'h0;
	endproperty
	a_seam: assert property (p_seam)
		else $error("gap between back-to-back read bursts");

	property p_full;
		@(posedge clk) disable iff (!rstn)
		is_rd |=> slot[$past(rl_idx)].valid;
	endproperty
	a_full: assert property (p_full)
		else $error("read command not queued");

	c_seam: cover property (p_seam);
	c_pre: cover property (@(posedge clk) disable iff (!rstn)
		$rose(dout.dqs_oe));
	c_wb: cover property (@(posedge clk) disable iff (!rstn)
		wb_req && !wb_we_i ##1 wb_ack_o);
endmodule : drt_top
`default_nettype wire

// *** bench/drt_ctl.sv ***
// Memory controller model: makes ck, drives commands, captures DQ/DQS.
// Assumes issue() is called at a ck fall, from one process at a time.
`timescale 1ns/1ps
`default_nettype none
module drt_ctl (
	input wire logic clk, // System clock.
	input wire drt_pkg::drt_dout_t dout, // Device read drive.
	output var logic ck, // Memory clock.
	output var drt_pkg::drt_cmd_t cmd // Command pins.
);
	int ecnt = 0;
	int cmd_edge = 0;
	logic [27:0] capq[$];
	initial
	begin
		ck = 1'b0;
		cmd = '1;
		// Count first, so that a process woken by this edge reads its index.
		forever
		begin
			#62.5;
			ecnt++;
			ck = ~ck;
		end
	end
	// The caller's gaps hold tRCD, tRC, tRRD, tRP and tRTP as ck counts.
	task automatic issue(input logic [3:0] code, input logic [1:0] ba,
		input logic [13:0] adr, input int gap);
		cmd <= {code, ba, adr};
		cmd_edge = ecnt + 1;
		@(negedge ck);
		if (gap > 1)
		begin
			cmd <= {4'hF, ~ba, ~adr};
			repeat (gap - 1) @(negedge ck);
		end
	endtask : issue
	// Sampling late in each half period keeps clear of the sync delay.
	always @(ck)
	begin : grab
		int e;
		e = ecnt;
		repeat (7) @(posedge clk);
		if (dout.dq_oe | dout.dqs_oe)
			capq.push_back({e[15:0], dout.dqs_oe, dout.dq_oe, dout.dqs,
				dout.dqs_n, dout.dq_oe ? dout.dq : 8'h00});
	end
endmodule : drt_ctl
`default_nettype wire

// *** bench/drt_top_tb.sv ***
// Self-checking bench for drt_top with the controller model on the link.
// Assumes a 125 MHz clk and a free-running 125 ns memory clock.
`timescale 1ns/1ps
`default_nettype none
module drt_top_tb;
	typedef struct packed {
		logic [2:0] cl;
		logic [2:0] al;
		logic bl8;
		logic ap;
		logic [1:0] ba;
		logic [9:0] col;
	} drt_row_t;
	localparam logic [7:0] SEED = 8'hA5;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic [31:0] rd;
	logic wb_ack_o;
	logic ck;
	drt_pkg::drt_cmd_t cmd;
	drt_pkg::drt_dout_t dout;
	int errors = 0;
	int n_compared = 0;
	drt_row_t rows[6] = '{
		'{3'h3, 3'h0, 1'b0, 1'b0, 2'h0, 10'h010},
		'{3'h4, 3'h1, 1'b0, 1'b1, 2'h1, 10'h0FE},
		'{3'h5, 3'h2, 1'b1, 1'b0, 2'h2, 10'h3FC},
		'{3'h3, 3'h2, 1'b1, 1'b1, 2'h3, 10'h100},
		'{3'h6, 3'h0, 1'b0, 1'b0, 2'h3, 10'h2F9},
		'{3'h4, 3'h3, 1'b1, 1'b1, 2'h0, 10'h055}};
	drt_top dut_u (.clk(clk), .rstn(rstn), .ck(ck), .cmd(cmd),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dout(dout));
	drt_ctl ctl_u (.clk(clk), .dout(dout), .ck(ck), .cmd(cmd));
	initial
	begin
		forever #4 clk = ~clk;
	end
	task automatic wrap_up;
		if (errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [3:0] adr,
		input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= dat;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 40);
		chk("ack", 32'h1, {31'h0, wb_ack_o});
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	function automatic logic [27:0] nxt();
		return ctl_u.capq.size() > 0 ? ctl_u.capq.pop_front() : '1;
	endfunction : nxt
	task automatic burst(input int e0, input logic [7:0] col,
		input int nel, input logic pre);
		for (int j = 2; j > 0 && pre; j--)
			chk("preamble", {4'h0, 16'(e0 - j), 12'h900}, {4'h0, nxt()});
		for (int k = 0; k < nel; k++)
			chk("beat", {4'h0, 16'(e0 + k), 2'b11, ~k[0], k[0],
				SEED + col + 8'(k)}, {4'h0, nxt()});
	endtask : burst
	task automatic run_row(input drt_row_t r);
		int rl;
		rl = int'(r.cl) + int'(r.al);
		wb(1'b1, drt_pkg::OFS_CTRL, {23'h0, r.bl8, 1'b0, r.al, 1'b0, r.cl});
		@(negedge ck);
		ctl_u.issue(drt_pkg::CMD_ACT, r.ba, 14'h0123, 3);
		ctl_u.issue(drt_pkg::CMD_RD, r.ba, {3'h0, r.ap, r.col}, rl + 8);
		burst(ctl_u.cmd_edge + 2 * rl, r.col[7:0], r.bl8 ? 8 : 4, 1'b1);
		chk("release", 32'h0, 32'(ctl_u.capq.size()));
		wb(1'b0, drt_pkg::OFS_STAT, 32'h0);
		chk("open", {31'h0, ~r.ap}, {31'h0, rd[r.ba]});
		if (!r.ap)
		begin
			@(negedge ck);
			ctl_u.issue(drt_pkg::CMD_PRE, r.ba, {3'h0, r.bl8, 10'h000}, 3);
		end
		wb(1'b0, drt_pkg::OFS_STAT, 32'h0);
		chk("closed", 32'h0, rd);
	endtask : run_row
	// Second READ two ck later: seamless for BL4, a truncation for BL8.
	task automatic two_rd(input logic bl8);
		int e;
		wb(1'b1, drt_pkg::OFS_CTRL, {23'h0, bl8, 8'h03});
		@(negedge ck);
		ctl_u.issue(drt_pkg::CMD_ACT, 2'h1, 14'h0042, 3);
		ctl_u.issue(drt_pkg::CMD_RD, 2'h1, 14'h0020, 2);
		e = ctl_u.cmd_edge;
		ctl_u.issue(drt_pkg::CMD_RD, 2'h1, 14'h0480, 14);
		burst(e + 6, 8'h20, 4, 1'b1);
		burst(e + 10, 8'h80, bl8 ? 8 : 4, 1'b0);
		chk("release", 32'h0, 32'(ctl_u.capq.size()));
		wb(1'b0, drt_pkg::OFS_STAT, 32'h0);
		chk("open", 32'h0, {31'h0, rd[1]});
	endtask : two_rd
	initial
	begin
		#200000;
		errors++;
		wrap_up();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		wb(1'b1, drt_pkg::OFS_SEED, {24'h0, SEED});
		for (int i = 0; i < 6; i++)
			run_row(rows[i]);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		ctl_u.capq.delete();
		wb(1'b0, drt_pkg::OFS_CTRL, 32'h0);
		chk("ctrl", {23'h0, drt_pkg::BL8_RST, 1'b0, drt_pkg::AL_RST, 1'b0,
			drt_pkg::CL_RST}, rd);
		wb(1'b0, drt_pkg::OFS_STAT, 32'h0);
		chk("stat", 32'h0, rd);
		wb(1'b0, drt_pkg::OFS_RDCNT, 32'h0);
		chk("rdcnt", 32'h0, rd);
		wb(1'b1, drt_pkg::OFS_SEED, {24'h0, SEED});
		two_rd(1'b0);
		two_rd(1'b1);
		wb(1'b1, 4'h2, 32'hFFFFFFFF);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, rd);
		wb(1'b1, drt_pkg::OFS_RDCNT, 32'h000000FF);
		wb(1'b0, drt_pkg::OFS_RDCNT, 32'h0);
		chk("rdcnt", 32'h4, rd);
		wrap_up();
	end
endmodule : drt_top_tb
`default_nettype wire
